//--- hw/wdcg_top.sv
// Design decisions made here: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
`include "wdcg_regs.svh"
module wdcg_top
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic legacy_compat_fuse_in,
	input wire logic always_on_fuse_in,
	output logic wd_enable_out,
	output logic [2:0] timeout_sel_out,
	output logic [21:0] timeout_period_out,
	output wdcg_pkg::wdcg_level_t safety_level_out
);
	import wdcg_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// period in watchdog oscillator cycles for a select code
	function automatic logic [21:0] period_of(input logic [2:0] sel);
		period_of = `WDCG_BASE_PERIOD << sel;
	endfunction

	// level from settled fuse values
	function automatic wdcg_level_t level_of(input logic aon, input logic compat);
		if (aon)
			level_of = WDCG_LVL2;
		else if (compat)
			level_of = WDCG_LVL0;
		else
			level_of = WDCG_LVL1;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [2:0] compat_sync; // fuse synchroniser, [0] first stage
	logic [2:0] aon_sync; // fuse synchroniser, [0] first stage
	wdcg_level_t level; // settled safety level
	logic wd_on; // software enable bit
	logic [2:0] tsel; // current time-out select
	logic [2:0] win_cnt; // unlock window cycles left
	logic next_on;
	logic [2:0] next_tsel;
	logic [2:0] next_cnt;
	wdcg_wr_t wr; // accepted write from the bus

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	wire [7:0] rd_value; // read image of the control register

	wdcg_avs_slave i_wdcg_avs_slave
	(
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.rd_value_in(rd_value),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.wr_out(wr)
	);

	// ----------------------------------------
	// fuse synchronisers
	// ----------------------------------------
	// fuses are static, but still come from outside the clock domain
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			compat_sync <= 3'h0;
			aon_sync <= 3'h0;
		end
		else if (ce_in)
		begin
			compat_sync <= {compat_sync[1:0], legacy_compat_fuse_in};
			aon_sync <= {aon_sync[1:0], always_on_fuse_in};
		end
	end

	// a change counts only when second and third stage agree
	wire fuses_settled = (compat_sync[1] == compat_sync[2]) && (aon_sync[1] == aon_sync[2]);

	// level register, starts at level 1 until the fuses are seen
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			level <= WDCG_LVL1;
		else if (ce_in && fuses_settled)
			level <= level_of(aon_sync[2], compat_sync[2]);
	end

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	wire wr_acc = wr.valid; // already gated by clock enable
	wire d_on = wr.data[`WDCG_ON_POS];
	wire d_unl = wr.data[`WDCG_UNLOCK_POS];
	wire [2:0] d_tsel = wr.data[`WDCG_TSEL_LSB +: 3];
	wire win_open = (win_cnt != 3'h0);
	wire is_l0 = (level == WDCG_LVL0);
	wire is_l2 = (level == WDCG_LVL2);
	// opening write: unlock and on written together
	wire opening = wr_acc & d_unl & d_on;
	// confirming write: unlock clear while the window is open
	wire confirm = wr_acc & ~d_unl & win_open;
	// at level 2 the on bit always reads one
	assign rd_value = {3'h0, win_open, wd_on | is_l2, tsel};

	// ----------------------------------------
	// next configuration
	// ----------------------------------------
	always_comb
	begin
		next_on = wd_on;
		next_tsel = tsel;
		// window runs down by itself
		next_cnt = win_open ? (win_cnt - 3'h1) : 3'h0;
		if (opening)
		begin
			// start window; writing one to on also enables
			next_cnt = `WDCG_WINDOW_CYCLES;
			if (!is_l2)
				next_on = 1'b1;
			// level 0 takes the select bits on any write
			if (is_l0)
				next_tsel = d_tsel;
		end
		else if (confirm)
		begin
			// second step applied, window closes
			next_cnt = 3'h0;
			next_tsel = d_tsel;
			// level 2 ignores the written on value
			if (!is_l2)
				next_on = d_on;
		end
		else if (wr_acc)
		begin
			// plain write: enabling is never restricted
			if (d_on)
				next_on = 1'b1;
			// locked levels keep the select, zero never disables
			if (is_l0)
				next_tsel = d_tsel;
		end
	end

	// ----------------------------------------
	// configuration registers and outputs
	// ----------------------------------------
	// select and on outputs load from next values; safety_level_out and the level 2 term of wd_enable_out lag the level register by one cycle
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wd_on <= `WDCG_ON_RESET;
			tsel <= `WDCG_TSEL_RESET;
			win_cnt <= 3'h0;
			wd_enable_out <= 1'b0;
			timeout_sel_out <= `WDCG_TSEL_RESET;
			timeout_period_out <= `WDCG_BASE_PERIOD;
			safety_level_out <= WDCG_LVL1;
		end
		else if (ce_in)
		begin
			wd_on <= next_on;
			tsel <= next_tsel;
			win_cnt <= next_cnt;
			wd_enable_out <= next_on | is_l2;
			timeout_sel_out <= next_tsel;
			timeout_period_out <= period_of(next_tsel);
			safety_level_out <= level;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);

	sequence s_open;
		opening;
	endsequence

	sequence s_idle4;
		(ce_in && !wr_acc) [*4];
	endsequence

	property p_l0_enable;
		wr_acc && d_on && is_l0 |=> wd_enable_out;
	endproperty
	a_l0_enable: assert property (p_l0_enable) else $error("level 0 enable lost");

	property p_l0_tsel;
		wr_acc && is_l0 |=> timeout_sel_out == $past(d_tsel);
	endproperty
	a_l0_tsel: assert property (p_l0_tsel) else $error("level 0 select not taken");

	property p_no_plain_disable;
		wr_acc && !d_on && !win_open && !is_l2 && wd_on |=> wd_enable_out;
	endproperty
	a_no_plain_disable: assert property (p_no_plain_disable) else $error("plain disable");

	property p_l1_enable;
		wr_acc && d_on && level == WDCG_LVL1 |=> wd_enable_out && wd_on;
	endproperty
	a_l1_enable: assert property (p_l1_enable) else $error("level 1 enable lost");

	property p_locked_tsel;
		wr_acc && !is_l0 && !confirm |=> $stable(timeout_sel_out);
	endproperty
	a_locked_tsel: assert property (p_locked_tsel) else $error("locked select changed");

	property p_l1_confirm;
		confirm && level == WDCG_LVL1 |=>
			(wd_enable_out == $past(d_on)) && (timeout_sel_out == $past(d_tsel));
	endproperty
	a_l1_confirm: assert property (p_l1_confirm) else $error("level 1 confirm wrong");

	property p_l2_on;
		is_l2 && $stable(level) |=> wd_enable_out && rd_value[`WDCG_ON_POS];
	endproperty
	a_l2_on: assert property (p_l2_on) else $error("level 2 not running");

	property p_l2_confirm;
		confirm && is_l2 |=> wd_enable_out && (timeout_sel_out == $past(d_tsel));
	endproperty
	a_l2_confirm: assert property (p_l2_confirm) else $error("level 2 confirm wrong");

	property p_window_load;
		s_open ##1 ce_in |-> win_cnt == `WDCG_WINDOW_CYCLES;
	endproperty
	a_window_load: assert property (p_window_load) else $error("window not four");

	property p_window_close;
		s_open ##1 s_idle4 |=> !rd_value[`WDCG_UNLOCK_POS];
	endproperty
	a_window_close: assert property (p_window_close) else $error("window stays open");

	property p_disable;
		confirm && !d_on && !is_l2 ##1 ce_in |-> !wd_enable_out;
	endproperty
	a_disable: assert property (p_disable) else $error("disable not applied");

	property p_period;
		ce_in ##1 ce_in |-> timeout_period_out == period_of(timeout_sel_out);
	endproperty
	a_period: assert property (p_period) else $error("period mismatch");

	property p_level;
		ce_in && fuses_settled ##1 ce_in |-> level == level_of($past(aon_sync[2]), $past(compat_sync[2]));
	endproperty
	a_level: assert property (p_level) else $error("level decode wrong");

endmodule

//--- hw/wdcg_regs.svh
`ifndef WDCG_REGS_SVH
`define WDCG_REGS_SVH

// ----------------------------------------
// register map and field layout
// ----------------------------------------
`define WDCG_CTRL_OFFSET 4'h0
`define WDCG_ON_POS 3
`define WDCG_UNLOCK_POS 4
`define WDCG_TSEL_LSB 0
`define WDCG_TSEL_RESET 3'h0
`define WDCG_ON_RESET 1'b0

// ----------------------------------------
// timing counts
// ----------------------------------------
`define WDCG_WINDOW_CYCLES 3'h4
`define WDCG_BASE_PERIOD 22'h004000

`endif

//--- hw/wdcg_pkg.sv
package wdcg_pkg;

	// ----------------------------------------
	// types shared by slave and core
	// ----------------------------------------
	// safety level, one-hot
	typedef enum logic [2:0]
	{
		WDCG_LVL0 = 3'b001,
		WDCG_LVL1 = 3'b010,
		WDCG_LVL2 = 3'b100
	} wdcg_level_t;

	// bus slave handshake state, one-hot
	typedef enum logic [1:0]
	{
		WDCG_BUS_IDLE = 2'b01,
		WDCG_BUS_DONE = 2'b10
	} wdcg_bus_state_t;

	// accepted write to the control register
	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
	} wdcg_wr_t;

endpackage

//--- hw/wdcg_avs_slave.sv
`timescale 1ns/1ns
`include "wdcg_regs.svh"
module wdcg_avs_slave
(
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [7:0] rd_value_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output wdcg_pkg::wdcg_wr_t wr_out
);
	import wdcg_pkg::*;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wdcg_bus_state_t state; // handshake phase
	wire hit = (avs_address_in == `WDCG_CTRL_OFFSET); // only one mapped word
	wire req = avs_read_in | avs_write_in; // any request pending
	wire [31:0] rd_word = (hit && avs_read_in) ? {24'h000000, rd_value_in} : 32'h00000000;

	// write takes effect only at the edge where waitrequest is seen low
	// one driver for the whole struct: valid in the top bit, data below
	assign wr_out = {ce_in & avs_write_in & ~avs_waitrequest_out & hit & avs_byteenable_in[0],
		avs_writedata_in[7:0]};

	// ----------------------------------------
	// fixed two-cycle answer
	// ----------------------------------------
	// every access costs two cycles, so two writes land at least two edges
	// apart, well inside the unlock window
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state <= WDCG_BUS_IDLE;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h00000000;
		end
		else if (ce_in)
		begin
			case (state)
				WDCG_BUS_IDLE:
				begin
					// request seen: answer next cycle
					if (req)
					begin
						state <= WDCG_BUS_DONE;
						avs_waitrequest_out <= 1'b0;
						avs_readdata_out <= rd_word;
					end
				end
				WDCG_BUS_DONE:
				begin
					// accept edge done, back to waiting
					state <= WDCG_BUS_IDLE;
					avs_waitrequest_out <= 1'b1;
				end
				default:
				begin
					state <= WDCG_BUS_IDLE;
					avs_waitrequest_out <= 1'b1;
				end
			endcase
		end
	end

endmodule

//--- test/tb_watchdog_config_guard.sv
`timescale 1ns/1ns
module tb_watchdog_config_guard;
	import wdcg_pkg::*;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [3:0] avs_addr = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_wdata = 32'h00000000;
	logic [3:0] avs_be = 4'hF;
	logic [31:0] avs_rdata;
	logic avs_wait;
	logic lc_fuse = 1'b0; // legacy compat fuse, high = programmed
	logic ao_fuse = 1'b0; // always-on fuse, high = programmed
	logic ce = 1'b1; // clock enable, dropped to freeze the block
	logic wd_en;
	logic [2:0] tsel;
	logic [21:0] period;
	wdcg_level_t level;
	logic [31:0] rdv; // read data of the last access
	int error_cnt = 0;
	int cmp_count = 0;

	wdcg_top i_wdcg_top
	(
		.clk_in(clk),
		.arst_n_in(arst_n),
		.ce_in(ce),
		.avs_address_in(avs_addr),
		.avs_read_in(avs_read),
		.avs_write_in(avs_write),
		.avs_writedata_in(avs_wdata),
		.avs_byteenable_in(avs_be),
		.avs_readdata_out(avs_rdata),
		.avs_waitrequest_out(avs_wait),
		.legacy_compat_fuse_in(lc_fuse),
		.always_on_fuse_in(ao_fuse),
		.wd_enable_out(wd_en),
		.timeout_sel_out(tsel),
		.timeout_period_out(period),
		.safety_level_out(level)
	);

	// 8 ns clock
	initial
	begin
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// compare and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// state of the outputs; period follows from the select code
	task automatic chk_st(input logic en, input logic [2:0] sel, input wdcg_level_t lvl);
		chk({31'h0, wd_en}, {31'h0, en});
		chk({29'h0, tsel}, {29'h0, sel});
		chk({10'h0, period}, {10'h0, 22'h004000 << sel});
		chk({29'h0, level}, {29'h0, lvl});
	endtask

	// entered just after a rising edge; request held until waitrequest low
	// no local wait limit: only the watchdog below ends a hang
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
		avs_write <= wr;
		avs_read <= ~wr;
		avs_addr <= a;
		avs_wdata <= {24'h000000, d};
		@(posedge clk);
		while (avs_wait !== 1'b0)
		begin
			@(posedge clk);
		end
		rdv = avs_rdata;
	endtask

	// release the bus, then one edge so registered outputs settle
	task automatic idle();
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] d);
		xfer(1'b1, 4'h0, d);
		idle();
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00);
		chk(rdv, exp);
		idle();
	endtask

	// opening write and confirm back to back: confirm lands two edges later
	task automatic seq(input logic [7:0] op, input logic [7:0] d);
		xfer(1'b1, 4'h0, op);
		xfer(1'b1, 4'h0, d);
		idle();
	endtask

	// fuses held steady through reset; wait until the level has settled
	task automatic rst(input logic lc, input logic ao);
		arst_n <= 1'b0;
		lc_fuse <= lc;
		ao_fuse <= ao;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_level0();
		rst(1'b1, 1'b0);
		chk_st(1'b0, 3'h0, WDCG_LVL0);
		for (int i = 0; i < 8; i++)
		begin
			wr({5'h00, i[2:0]});
			chk_st(1'b0, i[2:0], WDCG_LVL0);
		end
		// writes without byte 0 or to another address change nothing
		avs_be <= 4'hE;
		wr(8'h0D);
		avs_be <= 4'hF;
		xfer(1'b1, 4'h4, 8'h0D);
		idle();
		chk_st(1'b0, 3'h7, WDCG_LVL0);
		wr(8'h0D);
		chk_st(1'b1, 3'h5, WDCG_LVL0);
		wr(8'h05);
		chk_st(1'b1, 3'h5, WDCG_LVL0);
		// open the window, read it back at once, then after it has closed
		xfer(1'b1, 4'h0, 8'h1D);
		rd(4'h0, 32'h0000001D);
		repeat (5) @(posedge clk);
		rd(4'h0, 32'h0000000D);
		wr(8'h05);
		chk_st(1'b1, 3'h5, WDCG_LVL0);
		seq(8'h1D, 8'h05);
		chk_st(1'b0, 3'h5, WDCG_LVL0);
	endtask

	task automatic t_level1();
		rst(1'b0, 1'b0);
		chk_st(1'b0, 3'h0, WDCG_LVL1);
		wr(8'h0B);
		chk_st(1'b1, 3'h0, WDCG_LVL1);
		wr(8'h03);
		chk_st(1'b1, 3'h0, WDCG_LVL1);
		seq(8'h18, 8'h0B);
		chk_st(1'b1, 3'h3, WDCG_LVL1);
		// confirm lands five edges after the opening write: too late
		xfer(1'b1, 4'h0, 8'h18);
		idle();
		repeat (2) @(posedge clk);
		wr(8'h06);
		chk_st(1'b1, 3'h3, WDCG_LVL1);
		rd(4'h4, 32'h00000000);
		seq(8'h18, 8'h03);
		chk_st(1'b0, 3'h3, WDCG_LVL1);
		rd(4'h0, 32'h00000003);
		// clock enable low freezes the open window, so a late confirm still lands
		xfer(1'b1, 4'h0, 8'h18);
		avs_write <= 1'b0;
		ce <= 1'b0;
		repeat (10) @(posedge clk);
		chk_st(1'b1, 3'h3, WDCG_LVL1);
		ce <= 1'b1;
		wr(8'h05);
		chk_st(1'b0, 3'h5, WDCG_LVL1);
	endtask

	task automatic t_level2();
		rst(1'b0, 1'b1);
		chk_st(1'b1, 3'h0, WDCG_LVL2);
		wr(8'h07);
		chk_st(1'b1, 3'h0, WDCG_LVL2);
		rd(4'h0, 32'h00000008);
		seq(8'h18, 8'h07);
		chk_st(1'b1, 3'h7, WDCG_LVL2);
		seq(8'h18, 8'h02);
		chk_st(1'b1, 3'h2, WDCG_LVL2);
		rst(1'b1, 1'b1);
		chk_st(1'b1, 3'h0, WDCG_LVL2);
	endtask

	// ----------------------------------------
	// verdict
	// ----------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		t_level0();
		t_level1();
		t_level2();
		wrap_up();
	end

	// the tests need well under 1000 cycles; cut a hang short
	initial
	begin
		#(8 * 20000);
		error_cnt++;
		wrap_up();
	end
endmodule
